/* File: bench/iarc_sva.sv */
// Checker for iarc_top, bound from the bench top.
// Assumes it sees only top ports and rebuilds both configs from writes.
`timescale 1ns/10ps
module iarc_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic aux_mode_wr,
    input wire logic [7:0] aux_mode_data,
    input wire logic finish_handshake,
    input wire logic set_pp_flag,
    input wire logic clear_pp_flag,
    input wire logic [7:0] eos_char_reg,
    input wire logic talker_active_state,
    input wire logic listener_active_state,
    input wire logic service_request_state,
    input wire logic [7:0] byte_out_reg,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    input wire logic rx_ready,
    input wire logic rfd,
    input wire logic read_valid,
    input wire logic read_strobe,
    input wire logic data_in_flag,
    input wire logic end_flag,
    input wire logic eoi_out,
    input wire logic ist,
    input wire logic irq_in,
    input wire logic int_pin
);
    logic [4:0] a_reg, b_reg;
    logic pp_reg, take, eosm, hold_reg;
    logic [7:0] m;
    logic [1:0] md;
    assign m = a_reg[4] ? iarc_pkg::MASK_8BIT : iarc_pkg::MASK_7BIT;
    assign take = rx_valid && rx_ready && listener_active_state;
    assign eosm = ((rx_data ^ eos_char_reg) & m) == 8'h00;
    assign md = a_reg[1:0];
    always_ff @(posedge clk) begin
        if (reset) begin
            a_reg <= 5'h00;
            b_reg <= 5'h00;
            pp_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (aux_mode_wr && aux_mode_data[7:5] == iarc_pkg::CODE_RECV_CFG)
                a_reg <= aux_mode_data[4:0];
            if (aux_mode_wr && aux_mode_data[7:5] == iarc_pkg::CODE_STAT_CFG)
                b_reg <= aux_mode_data[4:0];
            pp_reg <= set_pp_flag || (pp_reg && !clear_pp_flag);
            // A holdoff starts on a byte and only the finish command ends it.
            if (take && (md == 2'b01 || (md[1] && (rx_end ||
                (eosm && a_reg[2])))))
                hold_reg <= 1'b1;
            else if (finish_handshake)
                hold_reg <= 1'b0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_idle: assert property ($past(reset) |-> rfd && !end_flag
        && !data_in_flag && !int_pin) else $error("not idle after reset");
    a_eoi_eos: assert property ($stable(a_reg) |-> eoi_out == $past(
        talker_active_state && a_reg[3] && ((byte_out_reg ^ eos_char_reg)
        & m) == 8'h00)) else $error("eoi wrong");
    a_end_on_eos: assert property (take && a_reg[2] && eosm |=> end_flag)
        else $error("end flag missed on eos");
    a_norm_read: assert property (read_strobe && read_valid && md == 2'b00
        |=> rfd) else $error("no rfd after read");
    a_hold_all: assert property (take && md == 2'b01 |=> !rfd [*4])
        else $error("hold all released early");
    a_hold_end: assert property (take && md == 2'b10 && a_reg[2] && eosm
        |=> !rfd [*4]) else $error("hold on end released early");
    a_fh_release: assert property (finish_handshake && hold_reg
        |=> rfd) else $error("finish did not release");
    a_cont_auto: assert property (take && md == 2'b11 && !a_reg[2]
        && !rx_end |-> ##[1:3] rfd) else $error("no auto ready");
    a_hold_keeps: assert property (hold_reg |-> !rfd)
        else $error("rfd raised during holdoff");
    a_di_cont: assert property ($rose(data_in_flag) |-> $past(md) != 2'b11)
        else $error("data-in set in continuous");
    a_ist_src: assert property ($stable(pp_reg) && $stable(b_reg) |->
        ist == $past(b_reg[4] ? service_request_state : pp_reg))
        else $error("ist source wrong");
    a_int_pol: assert property ($stable(b_reg) |->
        int_pin == $past(irq_in ^ b_reg[3])) else $error("int pin wrong");
    cover property (take && md == 2'b11);
    cover property (finish_handshake && !rfd);
    cover property (eoi_out);
endmodule

/* File: bench/iarc_talker_model.sv */
// Far-side talker that offers one byte at a time to the acceptor inputs.
// Assumes one clock; a byte stays offered until rx_ready is seen.
`timescale 1ns/10ps
module iarc_talker_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic [7:0] go_data,
    input wire logic go_end,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end
);
    // Released lines show the inverse so a stale byte cannot pass as new.
    always @(posedge clk) begin
        if (reset) begin
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_end <= 1'b0;
        end else if (go) begin
            rx_valid <= 1'b1;
            rx_data <= go_data;
            rx_end <= go_end;
        end else if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            rx_end <= ~rx_end;
        end
    end
endmodule

/* File: bench/iarc_top_tb.sv */
// Self-checking bench for iarc_top with the talker model on its input.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module iarc_top_tb;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] out;
        logic eoi;
    } iarc_row_t;
    logic clk, reset, aux_mode_wr, finish_handshake, set_pp_flag;
    logic clear_pp_flag, talker_active_state, listener_active_state;
    logic service_request_state, rx_valid, rx_end, rx_ready, rfd, rdy_msg;
    logic read_valid, read_strobe, data_in_flag, end_flag, clear_data_in;
    logic clear_end, eoi_out, ist, irq_in, int_pin, go, go_end;
    logic [7:0] aux_mode_data, eos_char_reg, byte_out_reg, rx_data;
    logic [7:0] read_data, go_data;
    int fails, n_compared, cyc, k;
    iarc_row_t rows [5] = '{'{8'h88, 8'h8A, 1'b1}, '{8'h98, 8'h8A, 1'b0},
        '{8'h98, 8'h0A, 1'b1}, '{8'h78, 8'h0A, 1'b1}, '{8'h80, 8'h0A, 1'b0}};
    iarc_top iarc_top_i (.clk, .reset, .aux_mode_wr, .aux_mode_data,
        .finish_handshake, .set_pp_flag, .clear_pp_flag, .eos_char_reg,
        .talker_active_state, .listener_active_state, .service_request_state,
        .byte_out_reg, .rx_valid, .rx_data, .rx_end, .rx_ready, .rfd, .rdy_msg,
        .read_data, .read_valid, .read_strobe, .data_in_flag, .end_flag,
        .clear_data_in, .clear_end, .eoi_out, .ist, .irq_in, .int_pin);
    iarc_talker_model iarc_talker_model_i (.clk, .reset, .go, .go_data,
        .go_end, .rx_ready, .rx_valid, .rx_data, .rx_end);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic aux(input logic [7:0] v);
        aux_mode_data = v;
        pulse(aux_mode_wr);
    endtask
    task automatic send(input logic [7:0] d, input logic e);
        go_data = d;
        go_end = e;
        pulse(go);
        for (k = 0; k < 20 && rx_valid === 1'b1; k++) tick(1);
    endtask
    task automatic rd(input logic [7:0] d);
        for (k = 0; k < 20 && read_valid !== 1'b1; k++) tick(1);
        chk(read_data === d, 1'b1);
        pulse(read_strobe);
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        {aux_mode_wr, finish_handshake, set_pp_flag, clear_pp_flag} = '0;
        {talker_active_state, listener_active_state, irq_in, go} = '0;
        {service_request_state, read_strobe, clear_data_in, clear_end} = '0;
        {aux_mode_data, byte_out_reg, go_data, go_end} = '0;
        eos_char_reg = 8'h0A;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        chk(rfd, 1'b1);
        chk(end_flag | data_in_flag | int_pin | read_valid, 1'b0);
        $display("reset test done");
        talker_active_state = 1'b1;
        foreach (rows[i]) begin
            byte_out_reg = rows[i].out;
            aux(rows[i].cmd);
            tick(1);
            chk(eoi_out, rows[i].eoi);
        end
        talker_active_state = 1'b0;
        $display("row tests done");
        aux(8'hB0);
        service_request_state = 1'b1;
        tick(2);
        chk(ist, 1'b1);
        service_request_state = 1'b0;
        tick(2);
        chk(ist, 1'b0);
        aux(8'hA0);
        pulse(set_pp_flag);
        tick(1);
        chk(ist, 1'b1);
        pulse(clear_pp_flag);
        tick(1);
        chk(ist, 1'b0);
        // inversion only briefly, then cleared again.
        aux(8'hA8);
        chk(int_pin, 1'b1);
        irq_in = 1'b1;
        tick(2);
        chk(int_pin, 1'b0);
        aux(8'hA0);
        chk(int_pin, 1'b1);
        irq_in = 1'b0;
        $display("status test done");
        listener_active_state = 1'b1;
        aux(8'h80);
        send(8'h41, 1'b0);
        chk(rfd, 1'b0);
        rd(8'h41);
        chk(rfd & data_in_flag, 1'b1);
        chk(rdy_msg, 1'b1);
        pulse(clear_data_in);
        aux(8'h81);
        send(8'h42, 1'b0);
        rd(8'h42);
        tick(3);
        chk(rfd, 1'b0);
        pulse(finish_handshake);
        chk(rfd, 1'b1);
        aux(8'h86);
        send(8'h41, 1'b0);
        rd(8'h41);
        chk(rfd, 1'b1);
        send(8'h0A, 1'b0);
        rd(8'h0A);
        tick(3);
        chk(rfd, 1'b0);
        chk(end_flag, 1'b1);
        pulse(clear_end);
        chk(end_flag, 1'b0);
        pulse(finish_handshake);
        chk(rfd, 1'b1);
        pulse(clear_data_in);
        aux(8'h83);
        send(8'h43, 1'b0);
        tick(2);
        chk(rfd, 1'b1);
        chk(data_in_flag, 1'b0);
        send(8'h44, 1'b1);
        tick(1);
        chk(rfd, 1'b0);
        pulse(finish_handshake);
        chk(rfd, 1'b1);
        $display("receive tests done");
        aux(8'h88);
        talker_active_state = 1'b1;
        byte_out_reg = 8'h0A;
        reset = 1'b1;
        tick(3);
        reset = 1'b0;
        chk(rfd, 1'b1);
        tick(2);
        chk(eoi_out, 1'b0);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
bind iarc_top iarc_sva iarc_sva_i (.clk, .reset, .aux_mode_wr, .aux_mode_data,
    .finish_handshake, .set_pp_flag, .clear_pp_flag, .eos_char_reg,
    .talker_active_state, .listener_active_state, .service_request_state,
    .byte_out_reg, .rx_valid, .rx_data, .rx_end, .rx_ready, .rfd, .read_valid,
    .read_strobe, .data_in_flag, .end_flag, .eoi_out, .ist, .irq_in, .int_pin);

/* File: include/iarc_pkg.sv */
// Package for the auxiliary receive configuration block.
// Assumes one clock domain and an 8-bit auxiliary mode port write strobe.
package iarc_pkg;
    localparam logic [2:0] CODE_RECV_CFG = 3'h4;
    localparam logic [2:0] CODE_STAT_CFG = 3'h5;
    localparam logic [11:0] AUX_MODE_PORT_OFFSET = 12'h11B;
    localparam logic [4:0] CFG_RESET = 5'h00;
    localparam int CODE_HI = 7;
    localparam int CODE_LO = 5;
    localparam int CMD_HI = 4;
    localparam int CMD_LO = 0;
    localparam int HOLD_HI = 1;
    localparam int HOLD_LO = 0;
    localparam int BIT_FULL_BYTE = 4;
    localparam int BIT_END_WITH_EOS = 3;
    localparam int BIT_END_ON_EOS = 2;
    localparam int BIT_STAT_SRC = 4;
    localparam int BIT_IRQ_FLIP = 3;
    localparam logic [7:0] MASK_7BIT = 8'h7F;
    localparam logic [7:0] MASK_8BIT = 8'hFF;

    typedef enum logic [1:0] {
        IARC_MODE_NORMAL = 2'b00,
        IARC_MODE_HOLD_ALL = 2'b01,
        IARC_MODE_HOLD_END = 2'b10,
        IARC_MODE_CONT = 2'b11
    } iarc_mode_t;

    typedef enum logic [1:0] {
        IARC_ST_READY = 2'b00,
        IARC_ST_WAIT_READ = 2'b01,
        IARC_ST_HOLDOFF = 2'b10
    } iarc_state_t;

    typedef struct packed {
        logic end_flag;
        logic [7:0] data;
    } iarc_rx_word_t;
endpackage

/* File: src/iarc_fifo.sv */
// Small synchronous FIFO for received bytes.
// Assumes both sides run on clk; depth is a power of two.
`timescale 1ns/10ps
module iarc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Pointers carry one extra wrap bit, so the depth must be a power of two.
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("iarc_fifo: bad WIDTH or DEPTH");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic push, pop;
    always_comb begin
        in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
        out_valid = wr_reg != rd_reg;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
        out_data = mem[rd_reg[AW-1:0]];
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

/* File: src/iarc_top.sv */
// Auxiliary receive and status configuration with the receive handshake.
// Assumes the host writes the auxiliary mode port with a one-cycle strobe
// and that the bus-side acceptor logic reports bytes on clk.
// What this block does
// - Code 100 writes store the low five bits into receive config.
// - Code 101 writes store the low five bits into status config.
// - Full-byte bit chooses 8-bit, else 7-bit, end-of-string comparison.
// - Talking with end-with-EOS set, EOI goes out with matching bytes.
// - Listening with end-on-EOS set, a matching byte sets END flag.
// - Holdoff bits pick normal, hold all, hold on end, or continuous.
// - Normal mode: reading the byte gives ready and raises RFD.
// - Hold-all mode: RFD stays false after each byte until finish.
// - Hold-on-end mode holds only at END or enabled EOS; finish releases.
// - Continuous mode gives ready automatically until end, then holds.
// - Continuous mode never sets the data-in flag.
// - Status-source bit picks service request state or parallel poll flag.
// - Parallel poll flag changes only by set and clear commands.
// - Polarity bit clear gives active-high interrupt pin, set active-low.
// - Both configs are write-only, reached only via the mode port.
`timescale 1ns/10ps
module iarc_top #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic aux_mode_wr,
    input wire logic [7:0] aux_mode_data,
    input wire logic finish_handshake,
    input wire logic set_pp_flag,
    input wire logic clear_pp_flag,
    input wire logic [7:0] eos_char_reg,
    input wire logic talker_active_state,
    input wire logic listener_active_state,
    input wire logic service_request_state,
    input wire logic [7:0] byte_out_reg,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    output logic rx_ready,
    output logic rfd,
    output logic rdy_msg,
    output logic [7:0] read_data,
    output logic read_valid,
    input wire logic read_strobe,
    output logic data_in_flag,
    output logic end_flag,
    input wire logic clear_data_in,
    input wire logic clear_end,
    output logic eoi_out,
    output logic ist,
    input wire logic irq_in,
    output logic int_pin
);
    if (FIFO_DEPTH != 8) begin
        $error("iarc_top: FIFO_DEPTH must be 8");
    end

    logic [4:0] recv_cfg_reg, recv_cfg_next;
    logic [4:0] stat_cfg_reg, stat_cfg_next;
    logic pp_flag_reg, pp_flag_next;
    logic di_reg, di_next, end_reg, end_next;
    logic eoi_reg, eoi_next;
    logic ist_reg, ist_next, int_reg, int_next;
    iarc_pkg::iarc_state_t st_reg, st_next;
    iarc_pkg::iarc_mode_t mode;
    iarc_pkg::iarc_rx_word_t f_in, f_out;
    logic f_in_ready, f_out_valid, f_out_ready;
    logic [7:0] rd_reg, rd_next;
    logic rv_reg, rv_next;
    logic rx_take, eos_hit, block_end;

    function automatic logic eos_match(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic full);
        logic [7:0] m;
        m = full ? iarc_pkg::MASK_8BIT : iarc_pkg::MASK_7BIT;
        return (a & m) == (b & m);
    endfunction

    // write-only decode through the mode port alone.
    always_comb begin
        recv_cfg_next = recv_cfg_reg;
        stat_cfg_next = stat_cfg_reg;
        if (aux_mode_wr) begin
            if (aux_mode_data[iarc_pkg::CODE_HI:iarc_pkg::CODE_LO] ==
                iarc_pkg::CODE_RECV_CFG) begin
                recv_cfg_next =
                    aux_mode_data[iarc_pkg::CMD_HI:iarc_pkg::CMD_LO];
            end
            if (aux_mode_data[iarc_pkg::CODE_HI:iarc_pkg::CODE_LO] ==
                iarc_pkg::CODE_STAT_CFG) begin
                stat_cfg_next =
                    aux_mode_data[iarc_pkg::CMD_HI:iarc_pkg::CMD_LO];
            end
        end
    end

    assign mode = iarc_pkg::iarc_mode_t'(
        recv_cfg_reg[iarc_pkg::HOLD_HI:iarc_pkg::HOLD_LO]);

    always_comb begin
        f_in.data = rx_data;
        f_in.end_flag = rx_end;
    end
    assign rx_ready = f_in_ready && st_reg == iarc_pkg::IARC_ST_READY;
    assign rx_take = rx_valid && rx_ready && listener_active_state;
    assign eos_hit = eos_match(rx_data, eos_char_reg,
                               recv_cfg_reg[iarc_pkg::BIT_FULL_BYTE]);
    assign block_end = rx_end ||
        (eos_hit && recv_cfg_reg[iarc_pkg::BIT_END_ON_EOS]);

    iarc_fifo #(
        .WIDTH($bits(iarc_pkg::iarc_rx_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) iarc_fifo_i (
        .clk(clk),
        .reset(reset),
        .in_valid(rx_take && mode != iarc_pkg::IARC_MODE_CONT),
        .in_ready(f_in_ready),
        .in_data(f_in),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );
    assign f_out_ready = !rv_reg || read_strobe;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            iarc_pkg::IARC_ST_READY: begin
                if (rx_take) begin
                    case (mode)
                        iarc_pkg::IARC_MODE_NORMAL:
                            st_next = iarc_pkg::IARC_ST_WAIT_READ;
                        iarc_pkg::IARC_MODE_HOLD_ALL:
                            st_next = iarc_pkg::IARC_ST_HOLDOFF;
                        iarc_pkg::IARC_MODE_HOLD_END:
                            st_next = block_end ?
                                iarc_pkg::IARC_ST_HOLDOFF :
                                iarc_pkg::IARC_ST_WAIT_READ;
                        iarc_pkg::IARC_MODE_CONT:
                            st_next = block_end ?
                                iarc_pkg::IARC_ST_HOLDOFF :
                                iarc_pkg::IARC_ST_READY;
                        default: st_next = iarc_pkg::IARC_ST_READY;
                    endcase
                end
            end
            iarc_pkg::IARC_ST_WAIT_READ: begin
                if (read_strobe && rv_reg) begin
                    st_next = iarc_pkg::IARC_ST_READY;
                end
            end
            iarc_pkg::IARC_ST_HOLDOFF: begin
                if (finish_handshake) begin
                    st_next = iarc_pkg::IARC_ST_READY;
                end
            end
            default: st_next = iarc_pkg::IARC_ST_READY;
        endcase
    end
    assign rfd = st_reg == iarc_pkg::IARC_ST_READY && f_in_ready;
    assign rdy_msg = rfd;

    always_comb begin
        rd_next = rd_reg;
        rv_next = rv_reg;
        if (f_out_valid && f_out_ready) begin
            rd_next = f_out.data;
            rv_next = 1'b1;
        end else if (read_strobe) begin
            rv_next = 1'b0;
        end
        // Set wins over clear so no received byte is lost.
        di_next = clear_data_in ? 1'b0 : di_reg;
        if (rx_take && mode != iarc_pkg::IARC_MODE_CONT) begin
            di_next = 1'b1;
        end
        end_next = clear_end ? 1'b0 : end_reg;
        if (rx_take && (rx_end || (eos_hit &&
            recv_cfg_reg[iarc_pkg::BIT_END_ON_EOS]))) begin
            end_next = 1'b1;
        end
        // EOI with a matching outgoing byte.
        eoi_next = talker_active_state &&
            recv_cfg_reg[iarc_pkg::BIT_END_WITH_EOS] &&
            eos_match(byte_out_reg, eos_char_reg,
                      recv_cfg_reg[iarc_pkg::BIT_FULL_BYTE]);
        // flag moves only by its commands.
        pp_flag_next = pp_flag_reg;
        if (set_pp_flag) begin
            pp_flag_next = 1'b1;
        end else if (clear_pp_flag) begin
            pp_flag_next = 1'b0;
        end
        ist_next = stat_cfg_reg[iarc_pkg::BIT_STAT_SRC] ?
            service_request_state : pp_flag_reg;
        int_next = irq_in ^ stat_cfg_reg[iarc_pkg::BIT_IRQ_FLIP];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            recv_cfg_reg <= iarc_pkg::CFG_RESET;
            stat_cfg_reg <= iarc_pkg::CFG_RESET;
            pp_flag_reg <= 1'b0;
            di_reg <= 1'b0;
            end_reg <= 1'b0;
            eoi_reg <= 1'b0;
            ist_reg <= 1'b0;
            int_reg <= 1'b0;
            st_reg <= iarc_pkg::IARC_ST_READY;
            rd_reg <= 8'h00;
            rv_reg <= 1'b0;
        end else begin
            recv_cfg_reg <= recv_cfg_next;
            stat_cfg_reg <= stat_cfg_next;
            pp_flag_reg <= pp_flag_next;
            di_reg <= di_next;
            end_reg <= end_next;
            eoi_reg <= eoi_next;
            ist_reg <= ist_next;
            int_reg <= int_next;
            st_reg <= st_next;
            rd_reg <= rd_next;
            rv_reg <= rv_next;
        end
    end

    assign read_data = rd_reg;
    assign read_valid = rv_reg;
    assign data_in_flag = di_reg;
    assign end_flag = end_reg;
    assign eoi_out = eoi_reg;
    assign ist = ist_reg;
    assign int_pin = int_reg;
endmodule
